//--- disk_io_defs.vh
// Constants for the disk file I/O interface
`ifndef DISK_IO_DEFS_VH
`define DISK_IO_DEFS_VH

// ****************************************
// Line and word formats
// ****************************************
`define WORD_W       48
`define LINE_W       49
`define PAR_BIT      48
`define BLK_WORDS    8
`define FACE_WORDS   4
`define JOB_W        45

// ****************************************
// Queuer request word fields
// ****************************************
`define JDA_HI       24
`define JDA_LO       0
`define JOP_HI       26
`define JOP_LO       25
`define JMA_HI       44
`define JMA_LO       27
`define DA_MOD_HI    24
`define DA_MOD_LO    18
`define DA_SEG_HI    17
`define OP_WRITE     2'h1

// ****************************************
// Disk organisation
// ****************************************
`define SEG_BITS     207
`define SEG_DWORDS   4
`define SEG_CHK      3
`define SEG_CLK      3
`define SEG_SPC      6
`define FACE_TRACKS  6'h32
`define TRACK_SEGS   18'h004e2
`define SET_SEGS     18'h01388
`define SET_STEP     13'h07d0
`define MAX_MODULES  7'h64
`define FACE_STREAMS 3

// ****************************************
// Timing, 100 MHz clock
// ****************************************
`define CLK_NS       10
`define WORD_NS      6000
`define PAIR_NS      (2 * `WORD_NS)
`define PAIR_CYC     (`PAIR_NS / `CLK_NS)
`define BURST_NS     100
`define BURST_CYC    (`BURST_NS / `CLK_NS)
`define REV_WORDS    14'h2710

// ****************************************
// Status codes, low bits of a status word
// ****************************************
`define ST_GOOD      4'h0
`define ST_PARITY    4'h1
`define ST_NOUNIT    4'h2
`define ST_REVLIM    4'h3

`endif

//--- seg_addr_decode.v
// Segment number to track, face set and BCD segment address
`include "disk_io_defs.vh"

module seg_addr_decode (
	input  wire        mclk,
	input  wire        reset,
	input  wire        clk_en,
	input  wire        start,
	input  wire [17:0] seg_num,
	output reg         done,
	output reg         bad,
	output reg  [5:0]  track,
	output reg  [1:0]  face_set,
	output reg  [15:0] seg_bcd
);

	reg [1:0]  phase_reg;
	reg [17:0] rem_reg;
	reg [28:0] dd;
	reg [12:0] lin;
	integer    i;
	integer    d;

	// Double dabble; set base is 2000 per face set
	always @* begin
		lin = (face_set * `SET_STEP) + rem_reg[12:0];
		dd = {16'h0000, lin};
		for (i = 0; i < 13; i = i + 1) begin
			for (d = 0; d < 4; d = d + 1) begin
				if (dd[13 + 4 * d +: 4] > 4'h4)
					dd[13 + 4 * d +: 4] = dd[13 + 4 * d +: 4] + 4'h3;
			end
			dd = dd << 1;
		end
	end

	// Repeated subtraction: slow but tiny, one decode per job
	always @(posedge mclk) begin
		if (reset) begin
			phase_reg <= 2'h0;
			rem_reg   <= 18'h00000;
			done      <= 1'b0;
			bad       <= 1'b0;
			track     <= 6'h00;
			face_set  <= 2'h0;
			seg_bcd   <= 16'h0000;
		end else if (clk_en) begin
			done <= 1'b0;
			case (phase_reg)
			2'h0: if (start) begin
				rem_reg   <= seg_num;
				track     <= 6'h00;
				face_set  <= 2'h0;
				bad       <= 1'b0;
				phase_reg <= 2'h1;
			end
			2'h1: if (rem_reg >= `SET_SEGS) begin
				rem_reg <= rem_reg - `SET_SEGS;
				track   <= track + 6'h01;
			end else
				phase_reg <= 2'h2;
			2'h2: if (rem_reg >= `TRACK_SEGS) begin
				rem_reg  <= rem_reg - `TRACK_SEGS;
				face_set <= face_set + 2'h1;
			end else
				phase_reg <= 2'h3;
			default: begin
				seg_bcd   <= dd[28:13];
				bad       <= (track >= `FACE_TRACKS);
				done      <= 1'b1;
				phase_reg <= 2'h0;
			end
			endcase
		end
	end

endmodule

//--- disk_file_io_interface.v
// Disk file controller interface to the I/O module channels
`include "disk_io_defs.vh"

module disk_file_io_interface #(
	parameter QDEPTH   = 8,
	parameter QPTR_W   = 3,
	parameter PAIR_CYC = `PAIR_CYC
) (
	input  wire        mclk,
	input  wire        reset,
	input  wire        clk_en,
	input  wire [48:0] ctl_in_data,
	input  wire        ctl_start,
	input  wire        ctl_sel_strobe,
	input  wire        ctl_last,
	output reg  [48:0] ctl_out_data,
	output reg         ctl_strobe,
	output reg         ctl_out_srq,
	output reg         ctl_in_srq,
	output reg         ctl_status,
	input  wire [48:0] q_data,
	input  wire        q_start,
	input  wire        q_strobe,
	output reg         q_srq,
	output reg         q_status,
	output wire [6:0]  disk_unit,
	output wire [1:0]  disk_set,
	output wire [5:0]  disk_track,
	output wire [15:0] disk_seg_bcd,
	output reg         disk_sel,
	output reg         disk_write,
	output wire [5:0]  disk_stream_en,
	output reg  [47:0] disk_wr_a,
	output reg  [47:0] disk_wr_b,
	output reg         disk_wr_stb,
	input  wire [47:0] disk_rd_a,
	input  wire [47:0] disk_rd_b,
	output wire        disk_rd_stb
);

	localparam S_IDLE  = 3'h0;
	localparam S_DEC   = 3'h1;
	localparam S_WFILL = 3'h2;
	localparam S_RFILL = 3'h3;
	localparam S_RSEND = 3'h4;
	localparam S_STAT  = 3'h5;
	// Wide on purpose; only the low bits reach the burst counter
	localparam [31:0] BURST_LAST = `BURST_CYC - 1;

	function odd_par;
		input [47:0] d;
		begin
			odd_par = ~^d;
		end
	endfunction

	// ****************************************
	// Queuer job queue, first in first out
	// ****************************************
	reg [`JOB_W-1:0] job_mem [0:QDEPTH-1];
	reg [QPTR_W-1:0] q_wr_reg;
	reg [QPTR_W-1:0] q_rd_reg;
	reg [QPTR_W:0]   q_cnt_reg;
	reg              q_wait_reg;
	wire             q_full;
	wire             q_pop;
	wire             q_push;
	reg [2:0]        state_reg;

	assign q_full = (q_cnt_reg == QDEPTH);
	assign q_pop  = clk_en && (state_reg == S_IDLE) && (q_cnt_reg != 0);
	assign q_push = clk_en && q_wait_reg && q_strobe && (^q_data);

	always @(posedge mclk) begin
		if (reset) begin
			q_wr_reg   <= {QPTR_W{1'b0}};
			q_rd_reg   <= {QPTR_W{1'b0}};
			q_cnt_reg  <= {(QPTR_W+1){1'b0}};
			q_wait_reg <= 1'b0;
			q_srq      <= 1'b0;
			q_status   <= 1'b0;
		end else if (clk_en) begin
			q_srq    <= 1'b0;
			q_status <= 1'b0;
			if (q_start && !q_full && !q_wait_reg) begin
				q_srq      <= 1'b1;
				q_wait_reg <= 1'b1;
			end
			if (q_wait_reg && q_strobe) begin
				q_wait_reg <= 1'b0;
				if (!(^q_data))
					q_status <= 1'b1;
			end
			if (q_push) begin
				job_mem[q_wr_reg] <= q_data[`JOB_W-1:0];
				q_wr_reg <= q_wr_reg + 1'b1;
			end
			if (q_pop)
				q_rd_reg <= q_rd_reg + 1'b1;
			if (q_push && !q_pop)
				q_cnt_reg <= q_cnt_reg + 1'b1;
			else if (q_pop && !q_push)
				q_cnt_reg <= q_cnt_reg - 1'b1;
		end
	end

	// ****************************************
	// Disk address decode
	// ****************************************
	reg [`JOB_W-1:0] job_reg;
	reg              dec_start_reg;
	wire             dec_done;
	wire             dec_bad;

	assign disk_unit = job_reg[`DA_MOD_HI:`DA_MOD_LO];
	assign disk_stream_en = {(2 * `FACE_STREAMS){disk_sel}};

	seg_addr_decode u_dec (
		.mclk     (mclk),
		.reset    (reset),
		.clk_en   (clk_en),
		.start    (dec_start_reg),
		.seg_num  (job_reg[`DA_SEG_HI:`JDA_LO]),
		.done     (dec_done),
		.bad      (dec_bad),
		.track    (disk_track),
		.face_set (disk_set),
		.seg_bcd  (disk_seg_bcd)
	);

	// ****************************************
	// Disk pacing
	// ****************************************
	reg [10:0] pace_reg;
	reg        tick_reg;

	// one face pair every 12 us
	always @(posedge mclk) begin
		if (reset) begin
			pace_reg <= 11'h000;
			tick_reg <= 1'b0;
		end else if (clk_en) begin
			tick_reg <= 1'b0;
			if (!disk_sel)
				pace_reg <= 11'h000;
			else if (pace_reg == PAIR_CYC - 1) begin
				pace_reg <= 11'h000;
				tick_reg <= 1'b1;
			end else
				pace_reg <= pace_reg + 11'h001;
		end
	end

	assign disk_rd_stb = clk_en && tick_reg && (state_reg == S_RFILL);

	// ****************************************
	// Controller data channel
	// ****************************************
	reg [47:0] dreg [0:`BLK_WORDS-1];
	reg [47:0] bufr [0:`BLK_WORDS-1];
	reg [3:0]  widx_reg;
	reg [1:0]  pidx_reg;
	reg [2:0]  sidx_reg;
	reg [3:0]  burst_reg;
	reg        buf_full_reg;
	reg        last_reg;
	reg [3:0]  err_reg;
	reg [13:0] rev_reg;
	wire       wmove;
	wire       rev_hit;
	integer    k;

	// Partial final block moves once last is seen and the buffer is free
	assign wmove = !buf_full_reg &&
		((widx_reg == `BLK_WORDS) || (last_reg && widx_reg != 4'h0));
	assign rev_hit = (rev_reg >= `REV_WORDS);

	always @(posedge mclk) begin
		if (reset) begin
			state_reg     <= S_IDLE;
			job_reg       <= {`JOB_W{1'b0}};
			dec_start_reg <= 1'b0;
			ctl_out_data  <= 49'h0;
			ctl_strobe    <= 1'b0;
			ctl_out_srq   <= 1'b0;
			ctl_in_srq    <= 1'b0;
			ctl_status    <= 1'b0;
			disk_sel      <= 1'b0;
			disk_write    <= 1'b0;
			disk_wr_a     <= 48'h0;
			disk_wr_b     <= 48'h0;
			disk_wr_stb   <= 1'b0;
			widx_reg      <= 4'h0;
			pidx_reg      <= 2'h0;
			sidx_reg      <= 3'h0;
			burst_reg     <= 4'h0;
			buf_full_reg  <= 1'b0;
			last_reg      <= 1'b0;
			err_reg       <= `ST_GOOD;
			rev_reg       <= 14'h0000;
		end else if (clk_en) begin
			dec_start_reg <= 1'b0;
			ctl_strobe    <= 1'b0;
			ctl_out_srq   <= 1'b0;
			ctl_in_srq    <= 1'b0;
			disk_wr_stb   <= 1'b0;
			case (state_reg)
			S_IDLE: if (q_cnt_reg != 0) begin
				job_reg       <= job_mem[q_rd_reg];
				dec_start_reg <= 1'b1;
				err_reg       <= `ST_GOOD;
				rev_reg       <= 14'h0000;
				last_reg      <= 1'b0;
				widx_reg      <= 4'h0;
				pidx_reg      <= 2'h0;
				buf_full_reg  <= 1'b0;
				state_reg     <= S_DEC;
			end
			S_DEC: if (dec_done) begin
				ctl_out_data <= {odd_par({30'h0,
					job_reg[`JMA_HI:`JMA_LO]}),
					30'h0, job_reg[`JMA_HI:`JMA_LO]};
				ctl_strobe <= 1'b1;
				ctl_status <= 1'b0;
				if (dec_bad || disk_unit >= `MAX_MODULES) begin
					err_reg   <= `ST_NOUNIT;
					state_reg <= S_STAT;
				end else if (job_reg[`JOP_HI:`JOP_LO] == `OP_WRITE) begin
					ctl_out_srq <= 1'b1;
					disk_sel    <= 1'b1;
					disk_write  <= 1'b1;
					state_reg   <= S_WFILL;
				end else begin
					disk_sel    <= 1'b1;
					disk_write  <= 1'b0;
					state_reg   <= S_RFILL;
				end
			end
			S_WFILL: begin
				// take word while select strobe high
				if (ctl_sel_strobe && !last_reg &&
					widx_reg != `BLK_WORDS) begin
					dreg[widx_reg[2:0]] <= ctl_in_data[47:0];
					widx_reg <= widx_reg + 4'h1;
					if (!(^ctl_in_data))
						err_reg <= `ST_PARITY;
					if (ctl_last)
						last_reg <= 1'b1;
				end
				if (wmove) begin
					for (k = 0; k < `BLK_WORDS; k = k + 1)
						bufr[k] <= (k < widx_reg) ? dreg[k] : 48'h0;
					buf_full_reg <= 1'b1;
					pidx_reg     <= 2'h0;
					widx_reg     <= 4'h0;
					if (!last_reg)
						ctl_out_srq <= 1'b1;
				end
				if (tick_reg && buf_full_reg) begin
					disk_wr_a   <= bufr[{1'b0, pidx_reg}];
					disk_wr_b   <= bufr[{1'b1, pidx_reg}];
					disk_wr_stb <= 1'b1;
					pidx_reg    <= pidx_reg + 2'h1;
					rev_reg     <= rev_reg + 14'h0002;
					if (pidx_reg == `SEG_DWORDS - 1)
						buf_full_reg <= 1'b0;
				end
				if (rev_hit) begin
					err_reg   <= `ST_REVLIM;
					state_reg <= S_STAT;
				end else if (last_reg && widx_reg == 4'h0 &&
					!buf_full_reg && !wmove)
					state_reg <= S_STAT;
			end
			S_RFILL: begin
				if (ctl_last)
					last_reg <= 1'b1;
				if (tick_reg) begin
					dreg[{1'b0, pidx_reg}] <= disk_rd_a;
					dreg[{1'b1, pidx_reg}] <= disk_rd_b;
					pidx_reg <= pidx_reg + 2'h1;
					rev_reg  <= rev_reg + 14'h0002;
					if (pidx_reg == `SEG_DWORDS - 1) begin
						ctl_in_srq <= 1'b1;
						sidx_reg   <= 3'h0;
						burst_reg  <= 4'h0;
						state_reg  <= S_RSEND;
					end
				end
			end
			S_RSEND: begin
				if (ctl_last)
					last_reg <= 1'b1;
				if (burst_reg != 4'h0)
					burst_reg <= burst_reg - 4'h1;
				else begin
					ctl_out_data <= {odd_par(dreg[sidx_reg]),
						dreg[sidx_reg]};
					ctl_strobe <= 1'b1;
					ctl_status <= 1'b0;
					sidx_reg   <= sidx_reg + 3'h1;
					burst_reg  <= BURST_LAST[3:0];
					if (sidx_reg == `BLK_WORDS - 1) begin
						pidx_reg <= 2'h0;
						if (rev_hit)
							err_reg <= `ST_REVLIM;
						if (rev_hit || last_reg || ctl_last)
							state_reg <= S_STAT;
						else
							state_reg <= S_RFILL;
					end
				end
			end
			// idle cycle after a word keeps strobes single
			S_STAT: if (!ctl_strobe) begin
				ctl_out_data <= {odd_par({44'h0, err_reg}),
					44'h0, err_reg};
				ctl_strobe <= 1'b1;
				ctl_status <= 1'b1;
				disk_sel   <= 1'b0;
				disk_write <= 1'b0;
				state_reg  <= S_IDLE;
			end
			default: state_reg <= S_IDLE;
			endcase
		end
	end

endmodule

//--- disk_io_sva.sv
// Port assertions for the disk file I/O interface
module disk_io_sva #(
	parameter PAIR_CYC = 1200
) (
	input logic        mclk,
	input logic        reset,
	input logic [48:0] q_data,
	input logic        q_start,
	input logic        q_strobe,
	input logic        q_srq,
	input logic        q_status,
	input logic [48:0] ctl_out_data,
	input logic        ctl_strobe,
	input logic        ctl_in_srq,
	input logic        ctl_status,
	input logic        disk_sel,
	input logic        disk_write,
	input logic [5:0]  disk_stream_en,
	input logic        disk_wr_stb,
	input logic        disk_rd_stb
);
	timeunit 1ns;
	timeprecision 1ps;
	int gap_reg;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	// ****
	// Pace counter
	// ****
	// Starts full so the first pair after reset is legal
	always @(posedge mclk)
		if (reset)
			gap_reg <= PAIR_CYC;
		else if (disk_wr_stb || disk_rd_stb)
			gap_reg <= 0;
		else if (gap_reg < PAIR_CYC)
			gap_reg <= gap_reg + 1;

	sequence s_word_first;
		ctl_strobe && !ctl_status;
	endsequence
	sequence s_word_gap;
		(!ctl_strobe) [*8] ##1 !ctl_strobe ##1 ctl_strobe;
	endsequence

	// ****
	// Assertions
	// ****
	a_srq_single: assert property (q_srq |=> !q_srq)
		else $error("queuer acknowledge too long");
	a_srq_cause: assert property (q_srq |-> $past(q_start))
		else $error("queuer acknowledge without start");
	a_parity_drop: assert property (q_strobe && !(^q_data) |=> q_status)
		else $error("bad request parity not flagged");
	a_status_cause: assert property (q_status |->
		$past(q_strobe) && !(^$past(q_data))) else $error("stray queuer status");
	a_out_parity: assert property (ctl_strobe |-> ^ctl_out_data)
		else $error("outgoing word parity not odd");
	a_status_rise: assert property ($rose(ctl_status) |-> ctl_strobe)
		else $error("status raised without word");
	a_in_burst: assert property (ctl_in_srq |=> s_word_first ##1 s_word_gap)
		else $error("input block pacing wrong");
	a_strobe_pulse: assert property (ctl_strobe |=> !ctl_strobe)
		else $error("word strobe longer than one cycle");
	a_stream_all: assert property (disk_stream_en == {6{disk_sel}})
		else $error("stream enables differ from select");
	a_pair_pace: assert property (disk_wr_stb || disk_rd_stb |->
		gap_reg >= PAIR_CYC - 1) else $error("disk pairs too close");
	a_write_path: assert property (disk_wr_stb |-> disk_sel && disk_write)
		else $error("disk write outside write job");
endmodule

bind disk_file_io_interface disk_io_sva #(.PAIR_CYC(PAIR_CYC)) u_sva (
	.mclk(mclk), .reset(reset), .q_data(q_data), .q_start(q_start),
	.q_strobe(q_strobe), .q_srq(q_srq), .q_status(q_status),
	.ctl_out_data(ctl_out_data), .ctl_strobe(ctl_strobe),
	.ctl_in_srq(ctl_in_srq), .ctl_status(ctl_status), .disk_sel(disk_sel),
	.disk_write(disk_write), .disk_stream_en(disk_stream_en),
	.disk_wr_stb(disk_wr_stb), .disk_rd_stb(disk_rd_stb)
);

//--- io_chan_model.sv
// Model of the I/O module channel that feeds the queuer
module io_chan_model (
	input  logic        mclk,
	input  logic        q_srq,
	output logic [48:0] q_data,
	output logic        q_start,
	output logic        q_strobe
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		q_data = '0;
		q_start = 1'b0;
		q_strobe = 1'b0;
	end

	task automatic send(input logic [47:0] w, input logic bad, output logic ok);
		int n;
		n = 0;
		q_start <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (q_srq !== 1'b1 && n < 200);
		ok = (q_srq === 1'b1);
		q_start <= 1'b0;
		// Random fetch delay, memory may be slow
		repeat ($urandom % 3) @(posedge mclk);
		q_strobe <= 1'b1;
		q_data <= {~^w ^ bad, w};
		@(posedge mclk);
		q_strobe <= 1'b0;
		q_data <= ~q_data;
	endtask
endmodule

//--- disk_file_io_interface_tb.sv
// Self-checking bench for the disk file I/O interface
`include "disk_io_defs.vh"
module disk_file_io_interface_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, reset, clk_en, ctl_start, ctl_sel_strobe, ctl_last;
	logic        q_start, q_strobe, q_srq, q_status, ctl_strobe, ctl_status;
	logic        ctl_out_srq, ctl_in_srq, disk_sel, disk_write;
	logic        disk_wr_stb, disk_rd_stb;
	logic [48:0] ctl_in_data, ctl_out_data, q_data;
	logic [47:0] disk_wr_a, disk_wr_b, disk_rd_a, disk_rd_b, e;
	logic [47:0] exp_q[$], ra[$], rb[$];
	logic [95:0] wr_q[$], e96;
	logic [15:0] disk_seg_bcd;
	logic [6:0]  disk_unit;
	logic [5:0]  disk_track, disk_stream_en;
	logic [3:0]  exp_code;
	logic [1:0]  disk_set;
	int          n_fail, n_checks;

	disk_file_io_interface #(.PAIR_CYC(4)) DUT (
		.mclk(mclk), .reset(reset), .clk_en(clk_en),
		.ctl_in_data(ctl_in_data), .ctl_start(ctl_start),
		.ctl_sel_strobe(ctl_sel_strobe), .ctl_last(ctl_last),
		.ctl_out_data(ctl_out_data), .ctl_strobe(ctl_strobe),
		.ctl_out_srq(ctl_out_srq), .ctl_in_srq(ctl_in_srq),
		.ctl_status(ctl_status), .q_data(q_data), .q_start(q_start),
		.q_strobe(q_strobe), .q_srq(q_srq), .q_status(q_status),
		.disk_unit(disk_unit), .disk_set(disk_set), .disk_track(disk_track),
		.disk_seg_bcd(disk_seg_bcd), .disk_sel(disk_sel),
		.disk_write(disk_write), .disk_stream_en(disk_stream_en),
		.disk_wr_a(disk_wr_a), .disk_wr_b(disk_wr_b),
		.disk_wr_stb(disk_wr_stb), .disk_rd_a(disk_rd_a),
		.disk_rd_b(disk_rd_b), .disk_rd_stb(disk_rd_stb)
	);
	io_chan_model pt (.mclk(mclk), .q_srq(q_srq), .q_data(q_data),
		.q_start(q_start), .q_strobe(q_strobe));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// ****
	// Checking tasks
	// ****
	function automatic logic [95:0] pw(input logic [47:0] w);
		return {47'h0, ~^w, w};
	endfunction

	task automatic chk(input string nm, input logic [95:0] ex, got);
		n_checks++;
		if (got !== ex) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", nm, ex, got);
		end
	endtask

	task automatic wait_for(input int s);
		logic [2:0] v;
		repeat (800) begin
			@(posedge mclk);
			v = {ctl_status, ctl_in_srq, ctl_out_srq};
			if (v[s] === 1'b1)
				return;
		end
		n_fail++;
		$display("unexpected wait %0d: expected 1, seen 0", s);
	endtask

	task automatic dchk(input int u, t, s, off, input logic wr);
		int b;
		b = s * 2000 + off;
		chk("unit", 96'(u), 96'(disk_unit));
		chk("track", 96'(t), 96'(disk_track));
		chk("set", 96'(s), 96'(disk_set));
		chk("bcd", 96'({4'(b / 1000), 4'(b / 100 % 10), 4'(b / 10 % 10),
			4'(b % 10)}), 96'(disk_seg_bcd));
		chk("write", 96'(wr), 96'(disk_write));
	endtask

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ****
	// Reference model
	// ****
	// Read pairs become a block: face A words first
	always @(posedge mclk) begin
		disk_rd_a <= 48'({$urandom, $urandom});
		disk_rd_b <= 48'({$urandom, $urandom});
		if (!reset && disk_rd_stb === 1'b1) begin
			ra.push_back(disk_rd_a);
			rb.push_back(disk_rd_b);
			if (ra.size() == 4) begin
				exp_q = {exp_q, ra, rb};
				ra = {};
				rb = {};
			end
		end
		if (!reset && disk_wr_stb === 1'b1) begin
			e96 = wr_q.size() ? wr_q.pop_front() : 'x;
			chk("disk pair", e96, {disk_wr_a, disk_wr_b});
		end
		if (!reset && ctl_strobe === 1'b1) begin
			e = (ctl_status === 1'b1) ? {44'h0, exp_code} :
				exp_q.size() ? exp_q.pop_front() : 'x;
			chk("ctl word", pw(e), 96'(ctl_out_data));
		end
	end

	initial begin
		#400000;
		n_fail++;
		$display("unexpected timeout: expected end, seen running");
		end_of_test();
	end

	// ****
	// Scenarios
	// ****
	initial begin
		int u, t, off;
		logic [17:0] ma;
		logic [24:0] da;
		logic [47:0] w[8];
		logic ok;
		n_fail = 0;
		n_checks = 0;
		exp_code = 4'h0;
		void'($urandom(38075));
		reset = 1'b1;
		clk_en = 1'b1;
		ctl_start = 1'b0;
		ctl_sel_strobe = 1'b0;
		ctl_last = 1'b0;
		ctl_in_data = '0;
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		// Even jobs write, odd jobs read, every face set once
		for (int s = 0; s < 4; s++) begin
			u = (s == 3) ? 99 : $urandom % 100;
			t = (s == 3) ? 49 : $urandom % 50;
			off = (s == 3) ? 1249 : $urandom % 1250;
			// Job 2 carries one word of even parity
			exp_code = (s == 2) ? `ST_PARITY : `ST_GOOD;
			ma = 18'($urandom);
			da = {7'(u), 18'(t * 5000 + s * 1250 + off)};
			exp_q.push_back({30'h0, ma});
			pt.send({3'h0, ma, s[0] ? 2'h0 : `OP_WRITE, da}, 1'b0, ok);
			chk("q_srq", 96'(1), 96'(ok));
			if (!s[0]) begin
				wait_for(0);
				dchk(u, t, s, off, 1'b1);
				foreach (w[k])
					w[k] = 48'({$urandom, $urandom});
				for (int k = 0; k < 4; k++)
					wr_q.push_back({w[k], w[k + 4]});
				ctl_start <= 1'b1;
				for (int k = 0; k < 8; k++) begin
					ctl_sel_strobe <= 1'b1;
					ctl_last <= (k == 7);
					ctl_in_data <= {~^w[k] ^ (s == 2 && k == 3), w[k]};
					@(posedge mclk);
				end
				ctl_start <= 1'b0;
				ctl_sel_strobe <= 1'b0;
				ctl_last <= 1'b0;
				ctl_in_data <= ~ctl_in_data;
			end else begin
				wait_for(1);
				dchk(u, t, s, off, 1'b0);
				ctl_last <= 1'b1;
				@(posedge mclk);
				ctl_last <= 1'b0;
			end
			wait_for(2);
			@(posedge mclk);
		end
		// Unit 100 and track 50 do not exist
		for (int j = 0; j < 2; j++) begin
			ma = 18'($urandom);
			da = j ? {7'h00, 18'h3d090} : {7'h64, 18'h00000};
			exp_q.push_back({30'h0, ma});
			exp_code = `ST_NOUNIT;
			pt.send({3'h0, ma, `OP_WRITE, da}, 1'b0, ok);
			chk("q_srq", 96'(1), 96'(ok));
			wait (ctl_status === 1'b0);
			wait_for(2);
			@(posedge mclk);
		end
		pt.send(48'({$urandom, $urandom}), 1'b1, ok);
		@(posedge mclk);
		chk("q_status", 96'(1), 96'(q_status));
		repeat (600) @(posedge mclk);
		chk("leftover", 96'(0), 96'(exp_q.size() + wr_q.size()));
		end_of_test();
	end
endmodule
